// File: tlcs_consts.vh
// Pointer map, reset values and status layout of the limit and status block
`ifndef TLCS_CONSTS_VH
`define TLCS_CONSTS_VH

`define TLCS_PTR_STATUS 8'h02
`define TLCS_PTR_LUP_HI_RD 8'h05
`define TLCS_PTR_LLO_HI_RD 8'h06
`define TLCS_PTR_RUP_HI_RD 8'h07
`define TLCS_PTR_RLO_HI_RD 8'h08
`define TLCS_PTR_LUP_HI_WR 8'h0B
`define TLCS_PTR_LLO_HI_WR 8'h0C
`define TLCS_PTR_RUP_HI_WR 8'h0D
`define TLCS_PTR_RLO_HI_WR 8'h0E
`define TLCS_PTR_RUP_LO 8'h13
`define TLCS_PTR_RLO_LO 8'h14
`define TLCS_PTR_LUP_LO 8'h16
`define TLCS_PTR_LLO_LO 8'h17
`define TLCS_PTR_RCRIT 8'h19
`define TLCS_PTR_LCRIT 8'h20
`define TLCS_PTR_HYST 8'h21

`define TLCS_RST_UP_HI 8'h55
`define TLCS_RST_UP_LO 4'h0
`define TLCS_RST_LO_HI 8'h00
`define TLCS_RST_LO_LO 4'h0
`define TLCS_RST_CRIT 8'h55
`define TLCS_RST_HYST 8'h0A
`define TLCS_RST_STATUS 8'h00
`define TLCS_UNMAPPED 8'h00

`define TLCS_ST_BUSY 7
`define TLCS_ST_LOCAL_OVER_UPPER_FLAG 6
`define TLCS_ST_LOCAL_UNDER_LOWER_FLAG 5
`define TLCS_ST_REMOTE_OVER_UPPER_FLAG 4
`define TLCS_ST_REMOTE_UNDER_LOWER_FLAG 3
`define TLCS_ST_OPEN 2
`define TLCS_ST_RCRIT 1
`define TLCS_ST_LCRIT 0

`endif

// File: tlcs_hyst_cmp.v
// Threshold comparator with hysteresis, updated at the end of a conversion
`timescale 1ns/10ps
module tlcs_hyst_cmp (
  input wire clk_sys,
  input wire reset,
  input wire update,
  input wire [11:0] temp,
  input wire [11:0] limit,
  input wire [7:0] hyst,
  output reg flag_q
);
  wire [11:0] hystFull;
  wire [11:0] lowEdge;
  reg flag_d;

  assign hystFull = {hyst, 4'h0};
  // Clamp at zero so a large hysteresis cannot wrap round
  assign lowEdge = (limit >= hystFull) ? (limit - hystFull) : 12'h000;

  always @* begin
    flag_d = flag_q;
    if (update) begin
      if (temp > limit) begin
        flag_d = 1'b1;
      end else if (temp <= lowEdge) begin
        flag_d = 1'b0;
      end
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

// File: tlcs_latch_flag.v
// Sticky status flag: set by an event, cleared by a status read once the cause is gone
`timescale 1ns/10ps
module tlcs_latch_flag (
  input wire clk_sys,
  input wire reset,
  input wire setEv,
  input wire cond,
  input wire clrRd,
  output reg flag_q
);
  wire flag_d;

  // Set wins over a clear in the same cycle
  assign flag_d = setEv | (flag_q & ~(clrRd & ~cond));

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

// File: tlcs_limit_status.v
// Limit registers, comparators, status byte and alert pin of a two-channel monitor
`timescale 1ns/10ps
`include "tlcs_consts.vh"
module tlcs_limit_status (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] regPtr,
  input wire regSecond,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [7:0] regRdData_q,
  input wire [11:0] localTemp,
  input wire [11:0] remoteTemp,
  input wire localDone,
  input wire remoteDone,
  input wire converting,
  input wire remoteConverting,
  input wire remoteOpenDet,
  input wire alert_pin_function_select,
  input wire alertMask,
  input wire alertResponseStb,
  output wire alertPending,
  input wire alertPinIn,
  output wire alertPinOut,
  output wire alertPinOe
);
  reg [7:0] localUpperHi_q;
  reg [3:0] localUpperLo_q;
  reg [7:0] localLowerHi_q;
  reg [3:0] localLowerLo_q;
  reg [7:0] remoteUpperHi_q;
  reg [3:0] remoteUpperLo_q;
  reg [7:0] remoteLowerHi_q;
  reg [3:0] remoteLowerLo_q;
  reg [7:0] localCritical_q;
  reg [7:0] remoteCritical_q;
  reg [7:0] hysteresis_q;
  reg [7:0] rdData_d;
  reg [7:0] effPtr;
  reg openSeen_q;
  reg openCond_q;
  reg [4:0] alertFlagsPrev_q;
  reg alertActive_q;
  wire alertActive_d;
  wire statusRead;
  wire [23:0] tempAll;
  wire [1:0] doneAll;
  wire [23:0] upperAll;
  wire [23:0] lowerAll;
  wire [15:0] critAll;
  wire [1:0] criticalFlag;
  wire [1:0] highLive;
  wire [1:0] highLatched;
  wire [1:0] lowLatched;
  wire [1:0] highEff;
  wire openFlag;
  wire openSet;
  wire [4:0] alertFlags;
  wire alertRise;
  wire [7:0] statusByte;

  // Second byte of a two-byte access lands on the low-byte pointer
  function [7:0] lowPtrOf;
    input [7:0] p;
    begin
      case (p)
        `TLCS_PTR_LUP_HI_RD, `TLCS_PTR_LUP_HI_WR: begin
          lowPtrOf = `TLCS_PTR_LUP_LO;
        end
        `TLCS_PTR_LLO_HI_RD, `TLCS_PTR_LLO_HI_WR: begin
          lowPtrOf = `TLCS_PTR_LLO_LO;
        end
        `TLCS_PTR_RUP_HI_RD, `TLCS_PTR_RUP_HI_WR: begin
          lowPtrOf = `TLCS_PTR_RUP_LO;
        end
        `TLCS_PTR_RLO_HI_RD, `TLCS_PTR_RLO_HI_WR: begin
          lowPtrOf = `TLCS_PTR_RLO_LO;
        end
        default: begin
          lowPtrOf = p;
        end
      endcase
    end
  endfunction

  always @* begin
    effPtr = regPtr;
    if (regSecond) begin
      effPtr = lowPtrOf(regPtr);
    end
  end

  // Threshold register writes
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      localUpperHi_q <= `TLCS_RST_UP_HI;
      localUpperLo_q <= `TLCS_RST_UP_LO;
      localLowerHi_q <= `TLCS_RST_LO_HI;
      localLowerLo_q <= `TLCS_RST_LO_LO;
      remoteUpperHi_q <= `TLCS_RST_UP_HI;
      remoteUpperLo_q <= `TLCS_RST_UP_LO;
      remoteLowerHi_q <= `TLCS_RST_LO_HI;
      remoteLowerLo_q <= `TLCS_RST_LO_LO;
      localCritical_q <= `TLCS_RST_CRIT;
      remoteCritical_q <= `TLCS_RST_CRIT;
      hysteresis_q <= `TLCS_RST_HYST;
    end else if (regWrStb) begin
      // Values are stored as written, low bytes keeping only bits 7:4; a range change never rewrites them
      case (effPtr)
        `TLCS_PTR_LUP_HI_WR: begin
          localUpperHi_q <= regWrData;
        end
        `TLCS_PTR_LUP_LO: begin
          localUpperLo_q <= regWrData[7:4];
        end
        `TLCS_PTR_LLO_HI_WR: begin
          localLowerHi_q <= regWrData;
        end
        `TLCS_PTR_LLO_LO: begin
          localLowerLo_q <= regWrData[7:4];
        end
        `TLCS_PTR_RUP_HI_WR: begin
          remoteUpperHi_q <= regWrData;
        end
        `TLCS_PTR_RUP_LO: begin
          remoteUpperLo_q <= regWrData[7:4];
        end
        `TLCS_PTR_RLO_HI_WR: begin
          remoteLowerHi_q <= regWrData;
        end
        `TLCS_PTR_RLO_LO: begin
          remoteLowerLo_q <= regWrData[7:4];
        end
        `TLCS_PTR_LCRIT: begin
          localCritical_q <= regWrData;
        end
        `TLCS_PTR_RCRIT: begin
          remoteCritical_q <= regWrData;
        end
        `TLCS_PTR_HYST: begin
          hysteresis_q <= regWrData;
        end
        default: begin
          hysteresis_q <= hysteresis_q;
        end
      endcase
    end
  end

  // Channel 0 is local, channel 1 remote
  assign tempAll = {remoteTemp, localTemp};
  assign doneAll = {remoteDone, localDone};
  assign upperAll = {remoteUpperHi_q, remoteUpperLo_q, localUpperHi_q, localUpperLo_q};
  assign lowerAll = {remoteLowerHi_q, remoteLowerLo_q, localLowerHi_q, localLowerLo_q};
  assign critAll = {remoteCritical_q, localCritical_q};
  assign statusRead = regRdStb & (effPtr == `TLCS_PTR_STATUS);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      wire [11:0] chTemp;
      wire overUpper;
      wire underLower;
      reg overCond_q;
      reg underCond_q;

      assign chTemp = tempAll[ch*12 +: 12];
      assign overUpper = chTemp > upperAll[ch*12 +: 12];
      assign underLower = chTemp < lowerAll[ch*12 +: 12];

      // Cause still present as seen by the latest conversion
      always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          overCond_q <= 1'b0;
          underCond_q <= 1'b0;
        end else if (doneAll[ch]) begin
          overCond_q <= overUpper;
          underCond_q <= underLower;
        end
      end

      tlcs_hyst_cmp uCrit (
        .clk_sys(clk_sys),
        .reset(reset),
        .update(doneAll[ch]),
        .temp(chTemp),
        .limit({critAll[ch*8 +: 8], 4'h0}),
        .hyst(hysteresis_q),
        .flag_q(criticalFlag[ch])
      );

      tlcs_hyst_cmp uHighLive (
        .clk_sys(clk_sys),
        .reset(reset),
        .update(doneAll[ch]),
        .temp(chTemp),
        .limit(upperAll[ch*12 +: 12]),
        .hyst(hysteresis_q),
        .flag_q(highLive[ch])
      );

      tlcs_latch_flag uHighLat (
        .clk_sys(clk_sys),
        .reset(reset),
        .setEv(doneAll[ch] & overUpper),
        .cond(overCond_q),
        .clrRd(statusRead),
        .flag_q(highLatched[ch])
      );

      tlcs_latch_flag uLowLat (
        .clk_sys(clk_sys),
        .reset(reset),
        .setEv(doneAll[ch] & underLower),
        .cond(underCond_q),
        .clrRd(statusRead),
        .flag_q(lowLatched[ch])
      );

      assign highEff[ch] = alert_pin_function_select ? highLive[ch] : highLatched[ch];
    end
  endgenerate

  // Open diode is only believed while a remote conversion runs
  assign openSet = remoteOpenDet & remoteConverting;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      openSeen_q <= 1'b0;
      openCond_q <= 1'b0;
    end else if (remoteDone) begin
      openSeen_q <= 1'b0;
      openCond_q <= openSeen_q | openSet;
    end else if (openSet) begin
      openSeen_q <= 1'b1;
    end
  end

  tlcs_latch_flag uOpen (
    .clk_sys(clk_sys),
    .reset(reset),
    .setEv(openSet),
    .cond(openCond_q | openSeen_q),
    .clrRd(statusRead),
    .flag_q(openFlag)
  );

  assign statusByte[`TLCS_ST_BUSY] = converting;
  assign statusByte[`TLCS_ST_LOCAL_OVER_UPPER_FLAG] = highEff[0];
  assign statusByte[`TLCS_ST_LOCAL_UNDER_LOWER_FLAG] = lowLatched[0];
  assign statusByte[`TLCS_ST_REMOTE_OVER_UPPER_FLAG] = highEff[1];
  assign statusByte[`TLCS_ST_REMOTE_UNDER_LOWER_FLAG] = lowLatched[1];
  assign statusByte[`TLCS_ST_OPEN] = openFlag;
  assign statusByte[`TLCS_ST_RCRIT] = criticalFlag[1];
  assign statusByte[`TLCS_ST_LCRIT] = criticalFlag[0];

  // Read mux; a status read returns the value before the clear takes hold
  always @* begin
    case (effPtr)
      `TLCS_PTR_STATUS: begin
        rdData_d = statusByte;
      end
      `TLCS_PTR_LUP_HI_RD: begin
        rdData_d = localUpperHi_q;
      end
      `TLCS_PTR_LUP_LO: begin
        rdData_d = {localUpperLo_q, 4'h0};
      end
      `TLCS_PTR_LLO_HI_RD: begin
        rdData_d = localLowerHi_q;
      end
      `TLCS_PTR_LLO_LO: begin
        rdData_d = {localLowerLo_q, 4'h0};
      end
      `TLCS_PTR_RUP_HI_RD: begin
        rdData_d = remoteUpperHi_q;
      end
      `TLCS_PTR_RUP_LO: begin
        rdData_d = {remoteUpperLo_q, 4'h0};
      end
      `TLCS_PTR_RLO_HI_RD: begin
        rdData_d = remoteLowerHi_q;
      end
      `TLCS_PTR_RLO_LO: begin
        rdData_d = {remoteLowerLo_q, 4'h0};
      end
      `TLCS_PTR_LCRIT: begin
        rdData_d = localCritical_q;
      end
      `TLCS_PTR_RCRIT: begin
        rdData_d = remoteCritical_q;
      end
      `TLCS_PTR_HYST: begin
        rdData_d = hysteresis_q;
      end
      default: begin
        rdData_d = `TLCS_UNMAPPED;
      end
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regRdData_q <= `TLCS_RST_STATUS;
    end else if (regRdStb) begin
      regRdData_q <= rdData_d;
    end
  end

  // Alert: any limit or open flag rising from 0 to 1 arms it; the critical flags do not
  assign alertFlags = {highEff[0], lowLatched[0], highEff[1], lowLatched[1], openFlag};
  assign alertRise = |(alertFlags & ~alertFlagsPrev_q);

  // Rise wins over an alert response in the same cycle; status reads do not touch it
  assign alertActive_d = alertRise | (alertActive_q & ~alertResponseStb);

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alertFlagsPrev_q <= 5'h00;
      alertActive_q <= 1'b0;
    end else begin
      alertFlagsPrev_q <= alertFlags;
      alertActive_q <= alertActive_d;
    end
  end

  // Mask hides the pin but keeps the alert state for the response address
  assign alertPending = alertActive_q & ~alert_pin_function_select;
  // Open-drain: only ever pulls low, read-back of the wire is not needed here
  assign alertPinOut = 1'b0;
  assign alertPinOe = alert_pin_function_select ? (highLive[0] | highLive[1])
                                                : (alertActive_q & ~alertMask);
endmodule

// File: tlcs_limit_status_assertions.sv
// Concurrent checks on the ports of the limit and status block
`timescale 1ns/10ps
module tlcs_limit_status_checker (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] regPtr,
  input wire regRdStb,
  input wire [7:0] regRdData_q,
  input wire localDone,
  input wire remoteDone,
  input wire converting,
  input wire remoteOpenDet,
  input wire alert_pin_function_select,
  input wire alertMask,
  input wire alertResponseStb,
  input wire alertPending,
  input wire alertPinOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  wire stRd = regRdStb && regPtr == 8'h02;
  // Any input that can raise a flag; such an input reaches the alert two edges later, one edge after the flag rises
  wire anyEv = localDone || remoteDone || remoteOpenDet;
  wire sel = alert_pin_function_select;
  a_busy_capture: assert property (stRd |=> regRdData_q[7] == $past(converting))
    else $error("busy bit not taken from converter");
  a_read_holds: assert property (!regRdStb |=> $stable(regRdData_q))
    else $error("read data changed without a read");
  a_lo_nibble: assert property (regRdStb && regPtr == 8'h16 |=> regRdData_q[3:0] == 4'h0)
    else $error("low byte bits 3:0 not zero");
  a_alert_cause: assert property ($rose(alertPending) |-> $past(anyEv, 2))
    else $error("alert raised without a flag event");
  a_alert_stays: assert property (alertPending && !alertResponseStb |=> alertPending)
    else $error("alert dropped without alert response");
  a_alert_clears: assert property (alertResponseStb && !$past(anyEv) |=> !alertPending)
    else $error("alert response did not clear alert");
  a_mask_hides: assert property (!sel && alertMask |-> !alertPinOe)
    else $error("masked alert drove the pin");
  a_pin_alert: assert property (!sel && !alertMask |-> alertPinOe == alertPending)
    else $error("pin does not follow alert");
  a_live_steady: assert property (sel && $past(sel) && !$past(localDone || remoteDone)
    |-> $stable(alertPinOe))
    else $error("second critical output moved between conversions");
  c_alert: cover property ($rose(alertPending));
  c_ack: cover property (alertPending ##1 !alertPending);
  c_second_crit: cover property (sel && alertPinOe);
endmodule

bind tlcs_limit_status tlcs_limit_status_checker u_chk (.clk_sys, .reset, .regPtr, .regRdStb,
  .regRdData_q, .localDone, .remoteDone, .converting, .remoteOpenDet,
  .alert_pin_function_select, .alertMask, .alertResponseStb, .alertPending, .alertPinOe);

// File: tlcs_host_model.sv
// Host side: byte accesses on the register port and the alert response
`timescale 1ns/10ps
module tlcs_host_model (
  input wire clk_sys,
  input wire [7:0] regRdData_q,
  output reg [7:0] regPtr,
  output reg regSecond,
  output reg [7:0] regWrData,
  output reg regWrStb,
  output reg regRdStb,
  output reg alertResponseStb
);
  initial begin
    regPtr = 8'h00;
    regSecond = 1'b0;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    alertResponseStb = 1'b0;
  end
  // One byte; a two-byte access is the high byte then the same pointer with regSecond
  task xfer(input [7:0] ptr, input sec, input wr, input [7:0] d, output [7:0] q);
    begin
      @(negedge clk_sys);
      regPtr = ptr;
      regSecond = sec;
      regWrData = d;
      regWrStb = wr;
      regRdStb = !wr;
      @(negedge clk_sys);
      q = regRdData_q;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      // Released lines show inverted values so stale data cannot pass
      regWrData = ~d;
      regPtr = ~ptr;
    end
  endtask
  task ack;
    begin
      @(negedge clk_sys);
      alertResponseStb = 1'b1;
      @(negedge clk_sys);
      alertResponseStb = 1'b0;
    end
  endtask
endmodule

// File: tlcs_limit_status_bench.sv
// Self-checking bench of the limit and status block
`timescale 1ns/10ps
module tlcs_limit_status_bench;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg [11:0] localTemp = 12'h000;
  reg [11:0] remoteTemp = 12'h000;
  reg localDone = 1'b0;
  reg remoteDone = 1'b0;
  reg converting = 1'b0;
  reg remoteConverting = 1'b0;
  reg remoteOpenDet = 1'b0;
  reg alert_pin_function_select = 1'b0;
  reg alertMask = 1'b0;
  wire [7:0] regPtr, regWrData, regRdData_q;
  wire regSecond, regWrStb, regRdStb, alertResponseStb, alertPending, alertPinOut, alertPinOe;
  // Open-drain pin with a pull-up
  wire alertPinIn = alertPinOe ? alertPinOut : 1'b1;
  int fails = 0;
  int testsRun = 0;
  int cycles = 0;
  reg [7:0] q;
  reg [7:0] m;
  reg [7:0] rp [0:12] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h13, 8'h14, 8'h16, 8'h17, 8'h19,
    8'h20, 8'h21, 8'h02, 8'h01};
  reg [7:0] rv [0:12] = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55,
    8'h55, 8'h0A, 8'h00, 8'h00};
  reg [7:0] wp [0:3] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E};
  reg [7:0] hp [0:3] = '{8'h05, 8'h06, 8'h07, 8'h08};
  reg [7:0] lp [0:3] = '{8'h16, 8'h17, 8'h13, 8'h14};
  always #12.5 clk_sys = ~clk_sys;
  tlcs_limit_status dut (.clk_sys, .reset, .regPtr, .regSecond, .regWrData, .regWrStb,
    .regRdStb, .regRdData_q, .localTemp, .remoteTemp, .localDone, .remoteDone, .converting,
    .remoteConverting, .remoteOpenDet, .alert_pin_function_select, .alertMask,
    .alertResponseStb, .alertPending, .alertPinIn, .alertPinOut, .alertPinOe);
  tlcs_host_model u_host (.clk_sys, .regRdData_q, .regPtr, .regSecond, .regWrData, .regWrStb,
    .regRdStb, .alertResponseStb);
  task check(input string what, input [7:0] seen, input [7:0] exp);
    begin
      testsRun = testsRun + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task rd(input [7:0] p, input s, input [7:0] e, input [7:0] mk = 8'hFF);
    begin
      u_host.xfer(p, s, 1'b0, 8'h00, q);
      check($sformatf("pointer %h", p), q & mk, e);
    end
  endtask
  task wr(input [7:0] p, input s, input [7:0] d);
    u_host.xfer(p, s, 1'b1, d, q);
  endtask
  // One conversion result; returns once the alert path has settled
  task conv(input rem, input [11:0] t);
    begin
      @(negedge clk_sys);
      remoteTemp = t;
      localTemp = t;
      remoteDone = rem;
      localDone = !rem;
      @(negedge clk_sys);
      remoteDone = 1'b0;
      localDone = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
  endtask
  task closeOut;
    begin
      $display("checks %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // About 250 cycles are needed; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      closeOut;
    end
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd(rp[i], 1'b0, rv[i]);
    end
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      wr(wp[i], 1'b0, {6'h10, i[1:0]});
      wr(wp[i], 1'b1, 8'h9F);
      rd(hp[i], 1'b0, {6'h10, i[1:0]});
      rd(hp[i], 1'b1, 8'h90);
      wr(lp[i], 1'b0, 8'h6C);
      wr(hp[i], 1'b0, 8'hEE);
      rd(lp[i], 1'b0, 8'h60);
      rd(hp[i], 1'b0, {6'h10, i[1:0]});
      wr(wp[i], 1'b0, i[0] ? 8'h10 : 8'h60);
      wr(wp[i], 1'b1, 8'h00);
    end
    wr(8'h02, 1'b0, 8'hFF);
    rd(8'h02, 1'b0, 8'h00);
    wr(8'h20, 1'b0, 8'h30);
    wr(8'h19, 1'b0, 8'h30);
    wr(8'h21, 1'b0, 8'h10);
    rd(8'h21, 1'b0, 8'h10);
    $display("test thresholds done");
    // Critical limit 300h, hysteresis 100h: set above 300h, clear at 200h
    for (int c = 0; c < 2; c++) begin
      m = {6'h00, c[0], !c[0]};
      conv(c[0], 12'h300);
      rd(8'h02, 1'b0, 8'h00, m);
      conv(c[0], 12'h301);
      rd(8'h02, 1'b0, m, m);
      rd(8'h02, 1'b0, m, m);
      conv(c[0], 12'h201);
      rd(8'h02, 1'b0, m, m);
      conv(c[0], 12'h200);
      rd(8'h02, 1'b0, 8'h00, m);
    end
    $display("test critical done");
    // 601h is above the 300h critical limit as well, so the local critical bit reads 1
    conv(1'b0, 12'h601);
    rd(8'h02, 1'b0, 8'h41);
    check("alert pin", {7'h00, alertPinOe}, 8'h01);
    check("alert pin level", {7'h00, alertPinIn}, 8'h00);
    rd(8'h02, 1'b0, 8'h41);
    conv(1'b0, 12'h600);
    rd(8'h02, 1'b0, 8'h41);
    rd(8'h02, 1'b0, 8'h01);
    check("alert after read", {7'h00, alertPending}, 8'h01);
    u_host.ack;
    check("alert after response", {7'h00, alertPending}, 8'h00);
    $display("test latched_high done");
    alertMask = 1'b1;
    conv(1'b1, 12'h0FF);
    conv(1'b1, 12'h100);
    check("masked alert", {7'h00, alertPending}, 8'h01);
    check("masked pin", {7'h00, alertPinOe}, 8'h00);
    rd(8'h02, 1'b0, 8'h09);
    rd(8'h02, 1'b0, 8'h01);
    remoteOpenDet = 1'b1;
    repeat (2) @(negedge clk_sys);
    rd(8'h02, 1'b0, 8'h00, 8'h04);
    remoteConverting = 1'b1;
    converting = 1'b1;
    repeat (2) @(negedge clk_sys);
    remoteOpenDet = 1'b0;
    rd(8'h02, 1'b0, 8'h84, 8'h84);
    converting = 1'b0;
    remoteConverting = 1'b0;
    alertMask = 1'b0;
    u_host.ack;
    $display("test low_open_mask done");
    // Local live high flag still stands from 601h; bring it to the hysteresis edge first
    conv(1'b0, 12'h500);
    alert_pin_function_select = 1'b1;
    conv(1'b1, 12'h601);
    rd(8'h02, 1'b0, 8'h10, 8'h10);
    check("second critical pin", {7'h00, alertPinOe}, 8'h01);
    conv(1'b1, 12'h501);
    rd(8'h02, 1'b0, 8'h10, 8'h10);
    conv(1'b1, 12'h500);
    rd(8'h02, 1'b0, 8'h00, 8'h10);
    check("second critical release", {7'h00, alertPinOe}, 8'h00);
    check("no alert in mode one", {7'h00, alertPending}, 8'h00);
    $display("test second_critical done");
    closeOut;
  end
endmodule
